// ===== rod_pkg.sv
// Constants, enumerations and the decoded-instruction record for the
// operand format decoder. Assumes a 32-bit instruction and data word.
package rod_pkg;

  // Word geometry
  localparam int WORD_W = 32;
  localparam int OPC_W = 6;
  localparam int SEL_W = 5;
  localparam int IMM_W = 16;
  localparam int PORT_W = 3;
  localparam int LANES = 4;
  localparam int REG_COUNT = 32;

  // Field positions as labelled: label 0 is the most significant bit
  localparam int OPC_FIRST = 0;
  localparam int DST_FIRST = 6;
  localparam int SRCA_FIRST = 11;
  localparam int SRCB_FIRST = 16;
  localparam int IMM_FIRST = 16;
  localparam int PORT_FIRST = 29;

  // Label to vector index: bit label n sits at index WORD_W-1-n
  localparam int OPC_HI = WORD_W - 1 - OPC_FIRST;
  localparam int DST_HI = WORD_W - 1 - DST_FIRST;
  localparam int SRCA_HI = WORD_W - 1 - SRCA_FIRST;
  localparam int SRCB_HI = WORD_W - 1 - SRCB_FIRST;
  localparam int IMM_HI = WORD_W - 1 - IMM_FIRST;
  localparam int PORT_HI = WORD_W - 1 - PORT_FIRST;

  // Opcode bits, counted from the opcode's least significant end
  localparam int OPC_FORMAT_BIT = 3;
  localparam int OPC_STORE_BIT = 2;
  localparam int OPC_LOGIC_BIT = 2;

  // Opcode values and classes
  localparam logic [OPC_W-1:0] OPC_IMM_PREFIX = 6'h2c;
  localparam logic [OPC_W-1:0] OPC_STREAM = 6'h1b;
  localparam logic [OPC_W-1:0] OPC_SHIFT = 6'h24;
  localparam logic [OPC_W-1:0] OPC_SPECIAL_REG = 6'h25;
  localparam logic [1:0] CLASS_ARITH = 2'h0;
  localparam logic [1:0] CLASS_ARITH_EXT = 2'h1;
  localparam logic [1:0] CLASS_LOGIC_BRANCH = 2'h2;
  localparam logic [1:0] CLASS_MEMORY = 2'h3;
  localparam logic [1:0] SIZE_CODE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_CODE_HALF = 2'h1;
  localparam logic [1:0] SIZE_CODE_WORD = 2'h2;

  // Byte lanes, bit LANES-1 is the lane at the lowest byte address
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [LANES-1:0] LANES_FIRST_BYTE = 4'h8;
  localparam logic [LANES-1:0] LANES_UPPER_HALF = 4'hc;
  localparam logic [LANES-1:0] LANES_LOWER_HALF = 4'h3;
  localparam logic [LANES-1:0] LANES_WORD = 4'hf;

  typedef enum logic {ROD_FMT_REG, ROD_FMT_IMM} rod_format_t;
  typedef enum logic [2:0] {
    ROD_GRP_ARITH, ROD_GRP_LOGIC, ROD_GRP_BRANCH, ROD_GRP_MEMORY,
    ROD_GRP_SPECIAL
  } rod_group_t;
  typedef enum logic [1:0] {
    ROD_SIZE_BYTE, ROD_SIZE_HALF, ROD_SIZE_WORD, ROD_SIZE_NONE
  } rod_size_t;

  typedef struct packed {
    logic valid;
    rod_format_t format;
    rod_group_t group;
    logic [OPC_W-1:0] opcode;
    logic [SEL_W-1:0] dest_sel;
    logic [SEL_W-1:0] source_sel_a;
    logic [SEL_W-1:0] source_sel_b;
    logic uses_sel_b;
    logic [WORD_W-1:0] operand_imm;
    logic imm_prefixed;
    logic stream_valid;
    logic [PORT_W-1:0] stream_port_select;
    logic mem_valid;
    logic mem_store;
    rod_size_t mem_size;
    logic [LANES-1:0] byte_enable;
    logic misaligned;
  } rod_decode_t;

endpackage

// ===== rod_decoder.sv
// Operand format decoder: splits each fetched word into format, group,
// register selectors, immediate, stream port and memory lane controls.
// Assumes fetch and execute share this clock and the core reset.
// Contract
// - Every instruction is one word, two formats
// - Register format yields two sources, one destination
// - Immediate format yields one source, 16-bit immediate
// - Prefix widens the following immediate to 32
// - Immediate format always yields one destination
// - Selectors address thirty-two 32-bit registers
// - Stream transfers carry 3-bit port designator
// - Sign extension replicates immediate top bit
// - Memory accesses aligned to their data size
// - Big-endian, bit 0 most significant
// - Word, half word and byte sizes supported
// - Five groups: arithmetic, logical, branch, memory, special
// - Opcode, destination, source a, source b fields
`timescale 1ns/1ns
`default_nettype none

module rod_decoder
  import rod_pkg::*;
#(
  parameter int REGS = rod_pkg::REG_COUNT
) (
  // Clock and control
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // From fetch
  input wire logic fetch_valid,
  input wire logic [rod_pkg::WORD_W-1:0] fetch_word,
  // Low address bits of the access that goes with this word
  input wire logic [1:0] access_addr_low,
  // To execute
  output var rod_pkg::rod_decode_t decode,
  output logic prefix_pending
);
  import rod_pkg::*;

  // Byte lanes for a size at a byte offset; none when misaligned
  function automatic logic [LANES-1:0] lanes_for(input rod_size_t size,
                                                 input logic [1:0] addr);
    logic [LANES-1:0] lanes;
    lanes = LANES_NONE;
    case (size)
      ROD_SIZE_BYTE: lanes = LANES_FIRST_BYTE >> addr;
      ROD_SIZE_HALF: begin
        if (!addr[0]) begin
          lanes = addr[1] ? LANES_LOWER_HALF : LANES_UPPER_HALF;
        end
      end
      ROD_SIZE_WORD: begin
        if (addr == 2'h0) begin
          lanes = LANES_WORD;
        end
      end
      default: lanes = LANES_NONE;
    endcase
    return lanes;
  endfunction

  // Prefix state: upper half of the next immediate
  logic [IMM_W-1:0] prefix_high;

  // Field extraction, labels counted from the most significant bit
  wire logic [OPC_W-1:0] opcode = fetch_word[OPC_HI -: OPC_W];
  wire logic [SEL_W-1:0] dest_field = fetch_word[DST_HI -: SEL_W];
  wire logic [SEL_W-1:0] srca_field = fetch_word[SRCA_HI -: SEL_W];
  wire logic [SEL_W-1:0] srcb_field = fetch_word[SRCB_HI -: SEL_W];
  wire logic [IMM_W-1:0] imm_field = fetch_word[IMM_HI -: IMM_W];
  wire logic [PORT_W-1:0] port_field =
    fetch_word[PORT_HI -: PORT_W];
  wire logic [1:0] op_class = opcode[OPC_W-1 -: 2];

  // Format from one opcode bit
  wire rod_format_t format = opcode[OPC_FORMAT_BIT] ? ROD_FMT_IMM
                                                    : ROD_FMT_REG;
  wire logic is_prefix = opcode == OPC_IMM_PREFIX;
  wire logic is_stream = opcode == OPC_STREAM;
  wire logic is_memory = op_class == CLASS_MEMORY;

  // Functional group
  wire logic upper_logic = !opcode[OPC_LOGIC_BIT] || opcode == OPC_SHIFT;
  wire logic upper_special = is_prefix || opcode == OPC_SPECIAL_REG;
  wire rod_group_t upper_group =
    upper_special ? ROD_GRP_SPECIAL :
    upper_logic ? ROD_GRP_LOGIC : ROD_GRP_BRANCH;
  wire rod_group_t group =
    is_stream ? ROD_GRP_SPECIAL :
    (op_class == CLASS_ARITH || op_class == CLASS_ARITH_EXT) ?
      ROD_GRP_ARITH :
    op_class == CLASS_LOGIC_BRANCH ? upper_group : ROD_GRP_MEMORY;

  // Immediate: prefixed to a full word, else sign extended
  wire logic use_prefix = prefix_pending && format == ROD_FMT_IMM;
  wire logic [WORD_W-1:0] sign_ext =
    {{(WORD_W-IMM_W){imm_field[IMM_W-1]}}, imm_field};
  wire logic [WORD_W-1:0] full_imm =
    use_prefix ? {prefix_high, imm_field} : sign_ext;

  // Memory size from the low opcode bits
  wire logic [1:0] size_code = opcode[1:0];
  wire rod_size_t mem_size =
    !is_memory ? ROD_SIZE_NONE :
    size_code == SIZE_CODE_BYTE ? ROD_SIZE_BYTE :
    size_code == SIZE_CODE_HALF ? ROD_SIZE_HALF :
    size_code == SIZE_CODE_WORD ? ROD_SIZE_WORD : ROD_SIZE_NONE;
  wire logic [LANES-1:0] lanes = lanes_for(mem_size, access_addr_low);
  // An unaligned or unsized access gets no lanes and is flagged
  wire logic misaligned = is_memory && lanes == LANES_NONE;

  // Selectors reach a register file of REGS entries
  wire logic [SEL_W-1:0] dest_sel =
    SEL_W'(dest_field % REGS);
  wire logic [SEL_W-1:0] srca_sel = SEL_W'(srca_field % REGS);
  wire logic [SEL_W-1:0] srcb_sel = SEL_W'(srcb_field % REGS);
  wire logic uses_b = format == ROD_FMT_REG && !is_stream;

  // Assemble the record in the cycle the word is presented
  rod_decode_t next_decode;
  always_comb begin
    next_decode = '0;
    next_decode.valid = fetch_valid;
    next_decode.format = format;
    next_decode.group = group;
    next_decode.opcode = opcode;
    next_decode.dest_sel = dest_sel;
    next_decode.source_sel_a = srca_sel;
    next_decode.source_sel_b = uses_b ? srcb_sel : '0;
    next_decode.uses_sel_b = uses_b;
    // Register format carries no immediate
    next_decode.operand_imm =
      format == ROD_FMT_IMM ? full_imm : '0;
    next_decode.imm_prefixed = use_prefix;
    next_decode.stream_valid = is_stream;
    next_decode.stream_port_select = is_stream ? port_field : '0;
    next_decode.mem_valid = is_memory;
    next_decode.mem_store = is_memory && opcode[OPC_STORE_BIT];
    next_decode.mem_size = mem_size;
    next_decode.byte_enable = lanes;
    next_decode.misaligned = misaligned;
  end

  // Prefix holds only for the instruction directly after it
  wire logic next_pending = fetch_valid ? is_prefix
                                        : prefix_pending;

  always_ff @(posedge clock) begin
    if (reset) begin
      decode <= '0;
      prefix_pending <= 1'b0;
      prefix_high <= '0;
    end else if (clock_enable) begin
      decode <= next_decode;
      prefix_pending <= next_pending;
      if (fetch_valid && is_prefix) begin
        prefix_high <= imm_field;
      end
    end
  end

endmodule // rod_decoder

`default_nettype wire

// ===== rod_decoder_props.sv
// Port checker for the operand format decoder.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/1ns
`default_nettype none
module rod_decoder_props
  import rod_pkg::*;
#(parameter int REGS = 32) (
  // Control
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // Fetch and execute sides
  input wire logic fetch_valid,
  input wire logic [rod_pkg::WORD_W-1:0] fetch_word,
  input wire logic [1:0] access_addr_low,
  input wire rod_pkg::rod_decode_t decode,
  input wire logic prefix_pending
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire cv = clock_enable & fetch_valid;
  wire [5:0] opc = fetch_word[31:26];
  property p_dst; clock_enable |=> decode.dest_sel ==
    $past(fetch_word[25:21]) && decode.source_sel_a ==
    $past(fetch_word[20:16]) % REGS; endproperty
  a_dst: assert property (p_dst) else $error("selector");
  property p_srcb; clock_enable && !fetch_word[29] && opc != 6'h1b
    |=> decode.source_sel_b == $past(fetch_word[15:11]); endproperty
  a_srcb: assert property (p_srcb) else $error("source b");
  property p_sext; cv && fetch_word[29] && !prefix_pending &&
    opc != 6'h2c |=> decode.operand_imm ==
    {{16{$past(fetch_word[15])}}, $past(fetch_word[15:0])}; endproperty
  a_sext: assert property (p_sext) else $error("sign ext");
  sequence s_pair; cv && opc == 6'h2c ##1
    cv && fetch_word[29] && opc != 6'h2c; endsequence
  property p_pair; s_pair |=> decode.imm_prefixed && decode.operand_imm
    == {$past(fetch_word[15:0], 2), $past(fetch_word[15:0])}; endproperty
  a_pair: assert property (p_pair) else $error("prefix");
  property p_pend; cv |=> prefix_pending == ($past(opc) == 6'h2c);
  endproperty
  a_pend: assert property (p_pend) else $error("pending");
  property p_port; clock_enable && opc == 6'h1b |=> decode.stream_valid
    && decode.stream_port_select == $past(fetch_word[2:0]); endproperty
  a_port: assert property (p_port) else $error("port");
  property p_align; clock_enable && opc[5:4] == 2'h3 && opc[1:0] != 2'h0
    && access_addr_low[0] |=> decode.misaligned; endproperty
  a_align: assert property (p_align) else $error("align");
  property p_hold; !clock_enable |=> $stable(decode); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  c_pair: cover property (s_pair);
  c_port: cover property (decode.stream_valid);
  c_mis: cover property (decode.misaligned);
endmodule // rod_decoder_props
bind rod_decoder rod_decoder_props #(.REGS(REGS)) i_rod_decoder_props (
  .clock(clock), .reset(reset), .clock_enable(clock_enable),
  .fetch_valid(fetch_valid), .fetch_word(fetch_word),
  .access_addr_low(access_addr_low), .decode(decode),
  .prefix_pending(prefix_pending));
`default_nettype wire

// ===== rod_fetch_model.sv
// Fetch stage model: one word per cycle into the decoder.
// Assumes bench requests change just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module rod_fetch_model
  import rod_pkg::*;
(
  // From the bench
  input wire logic clock,
  input wire logic rq_ce,
  input wire logic rq_v,
  input wire logic [rod_pkg::WORD_W-1:0] rq_w,
  input wire logic [1:0] rq_a,
  // To the decoder
  output logic ce,
  output logic fv,
  output logic [rod_pkg::WORD_W-1:0] fw,
  output logic [1:0] fa
);
  initial {ce, fv, fw, fa} = '0;
  // Idle word flips each cycle so nothing stale looks valid
  always @(negedge clock) begin
    ce <= rq_ce;
    fv <= rq_v;
    fw <= rq_v ? rq_w : ~fw;
    fa <= rq_a;
  end
endmodule // rod_fetch_model
`default_nettype wire

// ===== risc_operand_format_decode_test.sv
// Bench for the operand format decoder behind a fetch model.
// Assumes decode shows one edge after the word is taken.
`timescale 1ns/1ns
`default_nettype none
module risc_operand_format_decode_test;
  import rod_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic rq_ce = 1'b1;
  logic rq_v = 1'b0;
  logic [31:0] rq_w = 32'h0;
  logic [1:0] rq_a = 2'h0;
  wire logic ce, fv, pend;
  wire logic [31:0] fw;
  wire logic [1:0] fa;
  wire rod_decode_t d;
  int num_errors = 0;
  int n_checks = 0;
  always #5 clock = ~clock;
  rod_fetch_model i_rod_fetch_model (.clock(clock), .rq_ce(rq_ce),
    .rq_v(rq_v), .rq_w(rq_w), .rq_a(rq_a), .ce(ce), .fv(fv),
    .fw(fw), .fa(fa));
  rod_decoder i_rod_decoder (.clock(clock), .reset(reset),
    .clock_enable(ce), .fetch_valid(fv), .fetch_word(fw),
    .access_addr_low(fa), .decode(d), .prefix_pending(pend));
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Starts just after a rising edge, ends once the answer shows
  task automatic send(logic [31:0] w, logic [1:0] a = 0, logic v = 1);
    {rq_w, rq_a, rq_v} = {w, a, v};
    @(posedge clock);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_formats;
    send({6'h00, 5'd3, 5'd17, 5'd31, 11'h0});
    chk({d.format, d.source_sel_b}, {1'b0, 5'd31});
    chk({d.valid, d.uses_sel_b}, 2'b11);
    chk({d.dest_sel, d.source_sel_a}, {5'd3, 5'd17});
    send({6'h08, 5'd9, 5'd31, 16'h8000});
    chk(d.operand_imm, 32'hffff8000);
    chk({d.format, d.dest_sel, d.source_sel_a}, {1'b1, 10'h13f});
  endtask
  task automatic t_prefix;
    send({6'h2c, 10'h0, 16'h1234});
    chk({pend, d.group}, {1'b1, ROD_GRP_SPECIAL});
    send(32'h0, 2'h0, 1'b0);
    chk({pend, d.valid}, 2'b10);
    send({6'h08, 5'd9, 5'd2, 16'h8000});
    chk(d.operand_imm, 32'h12348000);
    chk({pend, d.imm_prefixed, d.dest_sel}, {2'b01, 5'd9});
  endtask
  task automatic t_stream;
    for (int p = 0; p < 8; p++) begin
      send({6'h1b, 5'd4, 18'h0, p[2:0]});
      chk({d.stream_valid, d.stream_port_select}, {1'b1, p[2:0]});
    end
  endtask
  task automatic t_groups;
    logic [5:0] op [5] = '{6'h00, 6'h24, 6'h26, 6'h30, 6'h25};
    for (int i = 0; i < 5; i++) begin
      send({op[i], 26'h0});
      chk(d.group, i);
    end
  endtask
  task automatic t_lanes;
    logic [3:0] e;
    for (int s = 0; s < 4; s++)
      for (int a = 0; a < 4; a++) begin
        e = s == 0 ? 4'h8 >> a : s == 1 ? (a == 0 ? 4'hc : a == 2 ?
          4'h3 : 4'h0) : (s == 2 && a == 0) ? 4'hf : 4'h0;
        send({4'hc, 2'(s), 26'h0}, 2'(a));
        chk({d.mem_size, d.byte_enable}, {2'(s), e});
        chk({d.mem_valid, d.misaligned}, {1'b1, e == 4'h0});
      end
    send({6'h36, 26'h0});
    chk({d.mem_store, d.mem_size}, {1'b1, ROD_SIZE_WORD});
  endtask
  task automatic t_freeze;
    send({6'h00, 5'd7, 21'h0});
    rq_ce = 1'b0;
    send({6'h00, 5'd12, 21'h0});
    chk(d.dest_sel, 5'd7);
    rq_ce = 1'b1;
    send({6'h00, 5'd12, 21'h0});
    chk(d.dest_sel, 5'd12);
  endtask
  initial begin
    repeat (12) @(negedge clock);
    // Reset clears the whole record, even the size code
    chk({d.valid, d.mem_size, pend}, 4'h0);
    reset = 1'b0;
    @(posedge clock);
    #1;
    // Idle words still decode, but never as valid
    chk({d.valid, pend}, 2'b00);
    t_formats;
    t_prefix;
    t_stream;
    t_groups;
    t_lanes;
    t_freeze;
    wrap_up;
  end
  initial begin
    repeat (2000) @(posedge clock);
    num_errors++;
    wrap_up;
  end
endmodule // risc_operand_format_decode_test
`default_nettype wire
